//--- inc/dtmu_map.svh
// Purpose: Register addresses, field positions and reset values of the trigger match unit
// Assumes: CSR-style access with a 12-bit address
// Notes: Definitions only
`ifndef DTMU_MAP_SVH
`define DTMU_MAP_SVH

`define DTMU_CTRL_ADDR 12'h7a1
`define DTMU_CMPV_ADDR 12'h7a2

`define DTMU_BIT_LOAD 0
`define DTMU_BIT_STORE 1
`define DTMU_BIT_EXEC 2
`define DTMU_BIT_UENA 3
`define DTMU_BIT_SENA 4
`define DTMU_BIT_RSVD 5
`define DTMU_BIT_MENA 6
`define DTMU_MATCH_LO 7
`define DTMU_MATCH_HI 10
`define DTMU_ACTION_LO 12
`define DTMU_ACTION_HI 15
`define DTMU_BIT_SEL 19
`define DTMU_BIT_HIT 20

`define DTMU_MATCH_EXACT 4'h0
`define DTMU_MATCH_NAPOT 4'h1
`define DTMU_ACTION_BRKPT 4'h0
`define DTMU_CMPV_RESET 32'h0000_0000
`define DTMU_ZERO32 32'h0000_0000

`endif

//--- inc/dtmu_pkg.sv
// Purpose: Types of the trigger match unit
// Assumes: Constants come from dtmu_map.svh
// Notes: State is one packed struct
package dtmu_pkg;

    typedef struct packed {
        logic [31:0] cmpv;
        logic [3:0] match;
        logic [3:0] action;
        logic menable;
        logic sel;
        logic hit;
        logic exec;
        logic store;
        logic load;
        logic [31:0] rdata;
        logic fire;
    } dtmu_state_t;

endpackage

//--- src/dtmu_trigger.sv
// Purpose: One debug trigger comparator with its control word and compare value
// Assumes: CSR accesses and pipeline observations are synchronous to mclk_in
// Notes: Read data and the hit output are registered, one cycle after the access
`timescale 1ns/1ps
`include "dtmu_map.svh"

// How it works
// - Match size zero fires only when the observed value equals the whole compare value, or all of it but bit zero for instruction addresses.
// - Match size one compares the top M bits, M being 31 minus the index of the lowest zero bit.
// - Only match sizes zero and one are honoured; other codes never match.
// - The trigger can fire in machine mode only when its machine enable bit is set; it resets clear.
// - The supervisor, user and adjacent reserved bits are read-only zero.
// - With execute select set, each executed instruction address is compared.
// - A control write that sets data select clears execute and load select.
// - With store select set, the store address or store data is compared as data select says.
// - With load select set, each load address is compared.
// - A breakpoint-exception trigger cannot fire while the global machine interrupt enable is clear.
// - Instruction address compares ignore bit zero of the compare value.
// - The compare value is a 32-bit read/write register that resets to zero.
// - Data select zero compares the access address, one compares the store data.
// - A firing trigger sets the hit flag, winning over a same-cycle control write; software may also set or clear it.
module dtmu_trigger
    import dtmu_pkg::*;
(
    input wire logic mclk_in,            // Core clock
    input wire logic reset_in,           // Synchronous reset, active high
    input wire logic csr_wr_in,          // CSR write strobe
    input wire logic csr_rd_in,          // CSR read strobe
    input wire logic [11:0] csr_addr_in, // CSR address
    input wire logic [31:0] csr_wdata_in,// CSR write data
    input wire logic mie_in,             // Global machine interrupt enable
    input wire logic ifu_valid_in,       // Instruction executed this cycle
    input wire logic [31:0] ifu_pc_in,   // Executed instruction address
    input wire logic ld_valid_in,        // Load access this cycle
    input wire logic [31:0] ld_addr_in,  // Load address
    input wire logic st_valid_in,        // Store access this cycle
    input wire logic [31:0] st_addr_in,  // Store address
    input wire logic [31:0] st_data_in,  // Store data
    output logic [31:0] csr_rdata_out,   // Registered read data
    output logic trig_fire_out,          // Trigger fired, one-cycle pulse
    output logic trig_sel_out,           // Data select bit
    output logic trig_hit_out,           // Hit flag
    output logic [3:0] trig_action_out   // Action field
);

    dtmu_state_t q;
    dtmu_state_t d;

    // ---------------------------------------------------------------
    // Compare helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] napot_mask(input logic [31:0] cmpv);
        // Ones above the lowest zero bit of the compare value
        logic [31:0] low_ones;
        low_ones = ~cmpv & (cmpv + 32'h0000_0001);
        napot_mask = ~((low_ones << 1) - 32'h0000_0001);
    endfunction

    function automatic logic cmp_hit(input logic [3:0] mode, input logic [31:0] cmpv,
                                     input logic [31:0] value, input logic ign0);
        logic [31:0] mask;
        mask = `DTMU_ZERO32;
        cmp_hit = 1'b0;
        unique case (mode)
            `DTMU_MATCH_EXACT: mask = ~`DTMU_ZERO32;
            `DTMU_MATCH_NAPOT: mask = napot_mask(cmpv);
            default: mask = `DTMU_ZERO32;
        endcase
        if (ign0)
        begin
            mask[0] = 1'b0;
        end
        if ((mode == `DTMU_MATCH_EXACT) || (mode == `DTMU_MATCH_NAPOT))
        begin
            cmp_hit = ((value ^ cmpv) & mask) == `DTMU_ZERO32;
        end
    endfunction

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    logic [31:0] ctrl_word;
    logic exec_m;
    logic ld_m;
    logic st_m;
    logic fire;

    always_comb
    begin
        d = q;
        ctrl_word = `DTMU_ZERO32;
        ctrl_word[`DTMU_BIT_LOAD] = q.load;
        ctrl_word[`DTMU_BIT_STORE] = q.store;
        ctrl_word[`DTMU_BIT_EXEC] = q.exec;
        ctrl_word[`DTMU_BIT_MENA] = q.menable;
        ctrl_word[`DTMU_MATCH_HI:`DTMU_MATCH_LO] = q.match;
        ctrl_word[`DTMU_ACTION_HI:`DTMU_ACTION_LO] = q.action;
        ctrl_word[`DTMU_BIT_SEL] = q.sel;
        ctrl_word[`DTMU_BIT_HIT] = q.hit;

        exec_m = q.exec && ifu_valid_in && cmp_hit(q.match, q.cmpv, ifu_pc_in, 1'b1);
        ld_m = q.load && ld_valid_in && cmp_hit(q.match, q.cmpv, ld_addr_in, 1'b0);
        st_m = q.store && st_valid_in
               && cmp_hit(q.match, q.cmpv, q.sel ? st_data_in : st_addr_in, 1'b0);
        fire = q.menable && (exec_m || ld_m || st_m)
               && !((q.action == `DTMU_ACTION_BRKPT) && !mie_in);
        d.fire = fire;

        if (csr_wr_in && (csr_addr_in == `DTMU_CMPV_ADDR))
        begin
            d.cmpv = csr_wdata_in;
        end
        if (csr_wr_in && (csr_addr_in == `DTMU_CTRL_ADDR))
        begin
            d.load = csr_wdata_in[`DTMU_BIT_LOAD];
            d.store = csr_wdata_in[`DTMU_BIT_STORE];
            d.exec = csr_wdata_in[`DTMU_BIT_EXEC];
            d.menable = csr_wdata_in[`DTMU_BIT_MENA];
            d.match = csr_wdata_in[`DTMU_MATCH_HI:`DTMU_MATCH_LO];
            d.action = csr_wdata_in[`DTMU_ACTION_HI:`DTMU_ACTION_LO];
            d.sel = csr_wdata_in[`DTMU_BIT_SEL];
            d.hit = csr_wdata_in[`DTMU_BIT_HIT];
            if (csr_wdata_in[`DTMU_BIT_SEL])
            begin
                d.exec = 1'b0;
                d.load = 1'b0;
            end
        end
        if (fire)
        begin
            d.hit = 1'b1;
        end

        d.rdata = `DTMU_ZERO32;
        if (csr_rd_in && (csr_addr_in == `DTMU_CTRL_ADDR))
        begin
            d.rdata = ctrl_word;
        end
        else if (csr_rd_in && (csr_addr_in == `DTMU_CMPV_ADDR))
        begin
            d.rdata = q.cmpv;
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            q <= '0;
            q.cmpv <= `DTMU_CMPV_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign csr_rdata_out = q.rdata;
    assign trig_fire_out = q.fire;
    assign trig_sel_out = q.sel;
    assign trig_hit_out = q.hit;
    assign trig_action_out = q.action;

endmodule

//--- tb/dtmu_trigger_properties.sv
// Purpose: Port checker of dtmu_trigger
// Assumes: Control word at 0x7a1, compare value at 0x7a2
// Notes: Bound to every dtmu_trigger
`timescale 1ns/1ps
`include "dtmu_map.svh"
module dtmu_trigger_properties (
    input wire logic mclk_in, reset_in, csr_wr_in, csr_rd_in, mie_in, // Clock, reset, strobes
    input wire logic ifu_valid_in, ld_valid_in, st_valid_in, // Access strobes
    input wire logic [11:0] csr_addr_in, // Address
    input wire logic [31:0] csr_wdata_in, csr_rdata_out, // Data
    input wire logic trig_fire_out, trig_hit_out, trig_sel_out, // Status
    input wire logic [3:0] trig_action_out // Action field
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    sequence ctl_wr; csr_wr_in && csr_addr_in == `DTMU_CTRL_ADDR; endsequence
    sequence cv_wr; csr_wr_in && csr_addr_in == `DTMU_CMPV_ADDR; endsequence
    sequence rd_of(a); csr_rd_in && csr_addr_in == a; endsequence
    AST_RST: assert property ($fell(reset_in) |-> !trig_fire_out && !trig_hit_out && csr_rdata_out == 0)
        else $error("outputs not clear after reset");
    AST_RSVD: assert property (rd_of(`DTMU_CTRL_ADDR) |=> csr_rdata_out[5:3] == 3'h0)
        else $error("reserved bits read nonzero");
    AST_SELCLR: assert property (ctl_wr ##0 csr_wdata_in[19] ##2 rd_of(`DTMU_CTRL_ADDR) |=>
        csr_rdata_out[2] == 0 && csr_rdata_out[0] == 0) else $error("select kept exec or load");
    AST_CMPV: assert property (cv_wr ##2 rd_of(`DTMU_CMPV_ADDR) |=> csr_rdata_out == $past(csr_wdata_in, 3))
        else $error("compare value lost");
    AST_MIE: assert property (trig_action_out == `DTMU_ACTION_BRKPT && !mie_in |=> !trig_fire_out)
        else $error("breakpoint fired with mie clear");
    AST_HIT: assert property (trig_fire_out |-> trig_hit_out)
        else $error("fire without hit flag");
    AST_CAUSE: assert property (trig_fire_out |-> $past(ifu_valid_in || ld_valid_in || st_valid_in))
        else $error("fire without access");
    AST_SEL: assert property (ctl_wr |=> trig_sel_out == $past(csr_wdata_in[19]) &&
        trig_action_out == $past(csr_wdata_in[15:12])) else $error("control fields not written");
endmodule
bind dtmu_trigger dtmu_trigger_properties u_props (.mclk_in, .reset_in, .csr_wr_in, .csr_rd_in, .mie_in,
    .ifu_valid_in, .ld_valid_in, .st_valid_in, .csr_addr_in, .csr_wdata_in, .csr_rdata_out, .trig_fire_out,
    .trig_hit_out, .trig_sel_out, .trig_action_out);

//--- tb/dtmu_core_model.sv
// Purpose: Core pipeline model issuing accesses
// Assumes: One access per go pulse
// Notes: Buses not in use carry the inverted value
`timescale 1ns/1ps
module dtmu_core_model (
    input wire logic mclk_in, // Core clock
    input wire logic go_in, // Issue one access
    input wire logic [1:0] kind_in, // Exec, load, store address, store data
    input wire logic [31:0] val_in, // Value to present
    output logic [2:0] vld_out, // Store, load, exec strobes
    output logic [31:0] pc_out, ld_out, sa_out, sd_out // Buses
);
    always_ff @(posedge mclk_in)
    begin
        vld_out <= go_in ? 3'h1 << (kind_in[1] ? 2'h2 : kind_in) : 3'h0;
        pc_out <= go_in && kind_in == 2'h0 ? val_in : ~val_in;
        ld_out <= go_in && kind_in == 2'h1 ? val_in : ~val_in;
        sa_out <= go_in && kind_in == 2'h2 ? val_in : ~val_in;
        sd_out <= go_in && kind_in == 2'h3 ? val_in : ~val_in;
    end
endmodule

//--- tb/tb_top.sv
// Purpose: Self-checking bench of dtmu_trigger
// Assumes: Control word at 0x7a1, compare value at 0x7a2
// Notes: Table rows first, then reset and register cases
`timescale 1ns/1ps
`include "dtmu_map.svh"
module tb_top;
    typedef struct packed {logic [31:0] cv, ctl, v; logic [1:0] k; logic mie, f;} dtmu_row_t;
    logic mclk_in = 0, reset_in = 1, csr_wr_in = 0, csr_rd_in = 0, mie_in = 0, go = 0, fire;
    logic [1:0] kind = 0;
    logic [2:0] vld;
    logic [11:0] csr_addr_in = 0;
    logic [31:0] csr_wdata_in = 0, val = 0, rdata, pc, la, sa, sd;
    int miscompares = 0, total_checks = 0, cyc = 0, n;
    dtmu_row_t rows [10] = '{
        {32'h1000, 32'h44, 32'h1000, 2'h0, 2'h3}, {32'h1001, 32'h44, 32'h1000, 2'h0, 2'h3},
        {32'h1000, 32'h41, 32'h1000, 2'h1, 2'h3}, {32'h1001, 32'h41, 32'h1000, 2'h1, 2'h2},
        {32'h1000, 32'h4, 32'h1000, 2'h0, 2'h2}, {32'h10ff, 32'hc2, 32'h1080, 2'h2, 2'h3},
        {32'h55, 32'h80042, 32'h55, 2'h3, 2'h3}, {32'h1000, 32'h44, 32'h1000, 2'h0, 2'h0},
        {32'h1000, 32'h1044, 32'h1000, 2'h0, 2'h1}, {32'h1000, 32'h144, 32'h1000, 2'h0, 2'h2}};
    dtmu_trigger u_dut (.mclk_in, .reset_in, .csr_wr_in, .csr_rd_in, .csr_addr_in, .csr_wdata_in, .mie_in,
        .ifu_valid_in(vld[0]), .ifu_pc_in(pc), .ld_valid_in(vld[1]), .ld_addr_in(la), .st_valid_in(vld[2]),
        .st_addr_in(sa), .st_data_in(sd), .csr_rdata_out(rdata), .trig_fire_out(fire), .trig_sel_out(),
        .trig_hit_out(), .trig_action_out());
    dtmu_core_model u_core (.mclk_in, .go_in(go), .kind_in(kind), .val_in(val), .vld_out(vld), .pc_out(pc),
        .ld_out(la), .sa_out(sa), .sd_out(sd));
    always #5 mclk_in = ~mclk_in;
    always @(posedge mclk_in)
        if (++cyc == 2000)
        begin
            miscompares++;
            results;
        end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        {csr_wr_in, csr_rd_in, csr_addr_in, csr_wdata_in} <= {w, !w, a, d};
        @(posedge mclk_in);
        {csr_wr_in, csr_rd_in} <= 2'h0;
        #1 if (!w) chk(csr_rdata_out_w(), d);
    endtask
    function automatic logic [31:0] csr_rdata_out_w();
        return rdata;
    endfunction
    task results;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge mclk_in);
        reset_in <= 1'h0;
        foreach (rows[i])
        begin
            acc(1'h1, `DTMU_CMPV_ADDR, rows[i].cv);
            acc(1'h1, `DTMU_CTRL_ADDR, rows[i].ctl);
            @(posedge mclk_in);
            {mie_in, go, kind, val} <= {rows[i].mie, 1'h1, rows[i].k, rows[i].v};
            @(posedge mclk_in);
            go <= 1'h0;
            n = 0;
            #1 repeat (5) #10 n += fire;
            chk(32'(n), 32'(rows[i].f));
        end
        $display("Table rows done");
        @(posedge mclk_in) reset_in <= 1'h1;
        repeat (2) @(posedge mclk_in);
        reset_in <= 1'h0;
        acc(1'h0, `DTMU_CMPV_ADDR, 32'h0);
        acc(1'h0, `DTMU_CTRL_ADDR, 32'h0);
        acc(1'h1, `DTMU_CMPV_ADDR, 32'ha5a5_5a5b);
        acc(1'h0, `DTMU_CMPV_ADDR, 32'ha5a5_5a5b);
        acc(1'h1, `DTMU_CTRL_ADDR, 32'hffff_ffff);
        acc(1'h0, `DTMU_CTRL_ADDR, 32'h0018_f7c2);
        acc(1'h0, 12'h7a3, 32'h0);
        $display("Register cases done");
        results;
    end
endmodule
